// ===== hw/opmode_pkg.sv
// package: register map, field layout, reset values and timing for the clock control block
package opmode_pkg;

  // ==========================================
  // register offsets (byte addresses)
  localparam logic [3:0] MODE_CTRL_OFS = 4'h0;
  localparam logic [3:0] MODE_EXT_OFS = 4'h4;
  localparam logic [3:0] MODE_STAT_OFS = 4'h8;

  // ==========================================
  // field positions of the mode control, extension and status registers
  localparam int HIGH_CLK_SELECT_BIT = 0;
  localparam int IDLE_ENABLE_BIT = 1;
  localparam int HIGH_OSC_READY_BIT = 2;
  localparam int LOW_OSC_READY_BIT = 3;
  localparam int DIV_SEL_LSB = 5;
  localparam int IDLE_CLK_KEEP_BIT = 7;
  localparam int POWER_DOWN_BIT = 0;
  localparam int WDT_EXPIRY_BIT = 1;

  // ==========================================
  // reset values
  localparam logic [2:0] DIV_SEL_RESET = 3'h0;
  localparam logic IDLE_ENABLE_RESET = 1'b1;
  localparam logic HIGH_CLK_SELECT_RESET = 1'b1;
  localparam logic IDLE_CLK_KEEP_RESET = 1'b0;

  // ==========================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int FAST_OSC_STABLE_NS = 1000;
  localparam int FAST_OSC_STABLE_CYC = (FAST_OSC_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ==========================================
  // types
  typedef enum {
    MODE_NORMAL, MODE_SLOW, MODE_HALT_CLK_OFF, MODE_HALT_CLK_ON,
    MODE_DORMANT_NO_WDT, MODE_DORMANT_WITH_WDT
  } op_mode_t;

  typedef struct packed {
    logic [2:0] clk_div_select;
    logic idle_enable;
    logic high_clk_select;
    logic idle_clk_keep;
  } mode_cfg_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic sys_clk_en;
    logic sub_clk_en;
    logic timebase_clk_en;
    logic fast_osc_en;
  } clk_gate_t;

endpackage

// ===== hw/glitchless_gate.sv
// clock gate that changes its enable only while the clock is low
`timescale 1ns/1ps
module glitchless_gate (
  input wire logic clk_in,
  input wire logic rst_b,
  input wire logic enable,
  output logic clk_out
);
  logic en_latched;

  // ==========================================
  // enable taken on the falling edge keeps pulses whole
  always_ff @(negedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      en_latched <= 1'b0;
    end else begin
      en_latched <= enable;
    end
  end

  assign clk_out = clk_in & en_latched;
endmodule // glitchless_gate

// ===== hw/fast_divider.sv
// divider of the fast clock: one-cycle tick at the selected ratio
`timescale 1ns/1ps
module fast_divider #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic [WIDTH-1:0] ratio_minus_one,
  output logic tick
);
  logic [WIDTH-1:0] count;

  // ==========================================
  // the ratio is sampled only at wrap so a change never cuts a period short
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == '0) begin
      count <= ratio_minus_one;
      tick <= 1'b1;
    end else begin
      count <= count - 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // fast_divider

// ===== hw/opmode_clock_ctrl.sv
// operating mode and core clock control with an AXI4-Lite register slave
`timescale 1ns/1ps

// How it works
// R1: cpu clock runs only in normal and slow modes, stopped in four halt modes.
// R2: normal mode takes the core clock from fast clock divided by 1 to 64.
// R3: divide select 000/001 pick sub clock, 010..111 pick fast/64 down to fast/2.
// R4: high clock select 1 gives undivided fast clock, else divide select decides.
// R5: moving from fast clock to sub clock switches the fast oscillator off.
// R6: slow mode uses the sub clock from the slow oscillator, fast clock off.
// R7: halt enters an idle mode when idle enable is 1, else a sleep mode.
// R8: sleep without watchdog stops the cpu and the sub clock.
// R9: sleep with watchdog stops the cpu but keeps the sub clock.
// R10: idle with clock keep 0 stops cpu and system clock, sub clock runs.
// R11: idle with clock keep 1 keeps system clock and sub clock, cpu stopped.
// R12: low oscillator ready reads 0 in sleep without watchdog, 1 within 1-2 slow cycles.
// R13: high oscillator ready is 0 at power-on, set when the fast oscillator is stable.
// R14: unimplemented bits of both control registers read as zero.
// R15: fast clock from the 8 MHz oscillator, sub clock from the 32 kHz oscillator.
// R16: software polls high oscillator ready before relying on full speed.
// R17: entering any halt mode sets power-down and clears watchdog expiry.
// R18: ratio changes never produce truncated core clock pulses; a source change switches the gate input mux at once and can cut a pulse.
// R19: timebase clock runs in normal, slow and idle modes, stops in sleep modes.
module opmode_clock_ctrl #(
  parameter int STABLE_CYC = opmode_pkg::FAST_OSC_STABLE_CYC
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic FAST_RC_OSC,
  input wire logic SLOW_RC_OSC,
  input wire logic HALT_EXEC,
  input wire logic WAKE_UP,
  input wire logic WDT_ENABLE,
  input wire logic WDT_EXPIRY_SET,
  input wire logic [3:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [3:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic CORE_CLOCK,
  output logic CPU_CLOCK,
  output logic SUB_CLOCK,
  output logic TIMEBASE_CLOCK,
  output logic FAST_OSC_ENABLE,
  output logic CORE_TICK,
  output logic [2:0] OP_MODE
);
  opmode_pkg::mode_cfg_t cfg;
  opmode_pkg::op_mode_t mode;
  opmode_pkg::clk_gate_t gate;
  logic high_osc_ready;
  logic low_osc_ready;
  logic power_down_flag;
  logic watchdog_expiry_flag;
  logic [$clog2(STABLE_CYC+1)-1:0] stable_count;
  logic [1:0] slow_hist;
  logic [1:0] low_ready_count;
  logic slow_sync1;
  logic slow_sync2;
  logic [5:0] ratio_minus_one;
  logic use_sub;
  logic div_tick;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic halt_mode;

  // ==========================================
  // source decode
  // R3: divide select map
  function automatic logic [5:0] ratio_of(input logic [2:0] sel);
    case (sel)
      3'h2: ratio_of = 6'h3F;
      3'h3: ratio_of = 6'h1F;
      3'h4: ratio_of = 6'h0F;
      3'h5: ratio_of = 6'h07;
      3'h6: ratio_of = 6'h03;
      3'h7: ratio_of = 6'h01;
      default: ratio_of = 6'h00;
    endcase
  endfunction

  // R4: high select overrides divide select
  assign use_sub = !cfg.high_clk_select && (cfg.clk_div_select[2:1] == 2'h0);
  // R2: undivided fast clock is ratio 1
  assign ratio_minus_one = cfg.high_clk_select ? 6'h00 : ratio_of(cfg.clk_div_select);
  assign halt_mode = (mode != opmode_pkg::MODE_NORMAL) && (mode != opmode_pkg::MODE_SLOW);

  // ==========================================
  // mode machine
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode <= opmode_pkg::MODE_NORMAL;
    end else begin
      case (mode)
        opmode_pkg::MODE_NORMAL, opmode_pkg::MODE_SLOW: begin
          // R7: idle or sleep chosen by idle enable
          if (HALT_EXEC) begin
            if (cfg.idle_enable) begin
              mode <= cfg.idle_clk_keep ? opmode_pkg::MODE_HALT_CLK_ON
                                        : opmode_pkg::MODE_HALT_CLK_OFF;
            end else begin
              mode <= WDT_ENABLE ? opmode_pkg::MODE_DORMANT_WITH_WDT
                                 : opmode_pkg::MODE_DORMANT_NO_WDT;
            end
          end else begin
            mode <= use_sub ? opmode_pkg::MODE_SLOW : opmode_pkg::MODE_NORMAL;
          end
        end
        default: begin
          if (WAKE_UP) begin
            mode <= use_sub ? opmode_pkg::MODE_SLOW : opmode_pkg::MODE_NORMAL;
          end
        end
      endcase
    end
  end

  // ==========================================
  // clock enables per mode
  always_comb begin
    gate = '0;
    case (mode)
      // R1: cpu runs in running modes only
      opmode_pkg::MODE_NORMAL, opmode_pkg::MODE_SLOW: begin
        gate.cpu_clk_en = 1'b1;
        gate.sys_clk_en = 1'b1;
        gate.sub_clk_en = 1'b1;
        gate.timebase_clk_en = 1'b1;
      end
      // R10: system clock stopped, sub clock on
      opmode_pkg::MODE_HALT_CLK_OFF: begin
        gate.sub_clk_en = 1'b1;
        gate.timebase_clk_en = 1'b1;
      end
      // R11: system clock kept for peripherals
      opmode_pkg::MODE_HALT_CLK_ON: begin
        gate.sys_clk_en = 1'b1;
        gate.sub_clk_en = 1'b1;
        gate.timebase_clk_en = 1'b1;
      end
      // R9: sub clock kept for the watchdog
      opmode_pkg::MODE_DORMANT_WITH_WDT: begin
        gate.sub_clk_en = 1'b1;
      end
      // R8: everything stopped
      default: begin
        gate = '0;
      end
    endcase
    // R5: fast oscillator off whenever the sub clock is the source
    // R6: slow mode keeps the fast clock off
    gate.fast_osc_en = gate.sys_clk_en && !use_sub;
  end

  assign FAST_OSC_ENABLE = gate.fast_osc_en;

  // ==========================================
  // clock outputs
  // R15: fast clock from the fast oscillator
  fast_divider #(.WIDTH(6)) u_div (
    .clk(FAST_RC_OSC),
    .rst_b(RST_B),
    .run(gate.fast_osc_en),
    .ratio_minus_one(ratio_minus_one),
    .tick(div_tick)
  );

  // R2: divider tick swallows fast pulses to give the selected ratio
  // R18: whole pulses for ratio and enable changes; the source mux ahead of u_sys and u_cpu is not guarded
  glitchless_gate u_sys (
    .clk_in(use_sub ? SLOW_RC_OSC : FAST_RC_OSC),
    .rst_b(RST_B),
    .enable(gate.sys_clk_en && (use_sub || div_tick)),
    .clk_out(CORE_CLOCK)
  );
  glitchless_gate u_cpu (
    .clk_in(use_sub ? SLOW_RC_OSC : FAST_RC_OSC),
    .rst_b(RST_B),
    .enable(gate.cpu_clk_en && (use_sub || div_tick)),
    .clk_out(CPU_CLOCK)
  );
  // R15: sub clock from the slow oscillator
  glitchless_gate u_sub (
    .clk_in(SLOW_RC_OSC),
    .rst_b(RST_B),
    .enable(gate.sub_clk_en),
    .clk_out(SUB_CLOCK)
  );
  // R19: timebase stopped in both sleep modes
  glitchless_gate u_tbc (
    .clk_in(SLOW_RC_OSC),
    .rst_b(RST_B),
    .enable(gate.timebase_clk_en),
    .clk_out(TIMEBASE_CLOCK)
  );

  // core tick in the register clock domain marks the divided rate
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      CORE_TICK <= 1'b0;
      OP_MODE <= 3'h0;
    end else begin
      CORE_TICK <= div_tick;
      OP_MODE <= 3'(mode);
    end
  end

  // ==========================================
  // oscillator ready flags
  // R13: high ready after the fast oscillator settles
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stable_count <= '0;
      high_osc_ready <= 1'b0;
    end else if (!gate.fast_osc_en) begin
      stable_count <= '0;
      high_osc_ready <= 1'b0;
    end else if (stable_count == ($bits(stable_count))'(STABLE_CYC)) begin
      high_osc_ready <= 1'b1;
    end else begin
      stable_count <= stable_count + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      slow_sync1 <= 1'b0;
      slow_sync2 <= 1'b0;
      slow_hist <= 2'h0;
    end else begin
      slow_sync1 <= SLOW_RC_OSC;
      slow_sync2 <= slow_sync1;
      slow_hist <= {slow_hist[0], slow_sync2};
    end
  end

  // R12: low ready cleared in sleep without watchdog, set after slow edges
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      low_ready_count <= 2'h0;
      low_osc_ready <= 1'b0;
    end else if (mode == opmode_pkg::MODE_DORMANT_NO_WDT) begin
      low_ready_count <= 2'h0;
      low_osc_ready <= 1'b0;
    end else if (slow_hist == 2'h1) begin
      if (low_ready_count == 2'h1) begin
        low_osc_ready <= 1'b1;
      end else begin
        low_ready_count <= low_ready_count + 1'b1;
      end
    end
  end

  // ==========================================
  // status flags; hardware set wins over software clear
  // R17: halt entry sets power-down, clears watchdog expiry
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      power_down_flag <= 1'b0;
      watchdog_expiry_flag <= 1'b0;
    end else if (HALT_EXEC && !halt_mode) begin
      power_down_flag <= 1'b1;
      watchdog_expiry_flag <= 1'b0;
    end else if (WDT_EXPIRY_SET) begin
      watchdog_expiry_flag <= 1'b1;
    end else if (BVALID && BREADY && aw_addr == opmode_pkg::MODE_STAT_OFS && w_lane0) begin
      power_down_flag <= w_data[opmode_pkg::POWER_DOWN_BIT];
      watchdog_expiry_flag <= w_data[opmode_pkg::WDT_EXPIRY_BIT];
    end
  end

  // ==========================================
  // AXI4-Lite write channel
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign w_lane0 = WSTRB[0];

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0;
      BVALID <= 1'b0;
      BRESP <= opmode_pkg::AXI_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
      end
      if (aw_held && w_held && !BVALID) begin
        BVALID <= 1'b1;
        BRESP <= (aw_addr == opmode_pkg::MODE_CTRL_OFS || aw_addr == opmode_pkg::MODE_EXT_OFS
                  || aw_addr == opmode_pkg::MODE_STAT_OFS) ? opmode_pkg::AXI_OKAY
                                                             : opmode_pkg::AXI_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  // control registers update as the response is accepted
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg.clk_div_select <= opmode_pkg::DIV_SEL_RESET;
      cfg.idle_enable <= opmode_pkg::IDLE_ENABLE_RESET;
      cfg.high_clk_select <= opmode_pkg::HIGH_CLK_SELECT_RESET;
      cfg.idle_clk_keep <= opmode_pkg::IDLE_CLK_KEEP_RESET;
    end else if (BVALID && BREADY && w_lane0) begin
      if (aw_addr == opmode_pkg::MODE_CTRL_OFS) begin
        cfg.clk_div_select <= w_data[opmode_pkg::DIV_SEL_LSB +: 3];
        cfg.idle_enable <= w_data[opmode_pkg::IDLE_ENABLE_BIT];
        cfg.high_clk_select <= w_data[opmode_pkg::HIGH_CLK_SELECT_BIT];
      end else if (aw_addr == opmode_pkg::MODE_EXT_OFS) begin
        cfg.idle_clk_keep <= w_data[opmode_pkg::IDLE_CLK_KEEP_BIT];
      end
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  assign ARREADY = !RVALID;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= opmode_pkg::AXI_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RRESP <= opmode_pkg::AXI_OKAY;
      RDATA <= 32'h0;
      // R14: unimplemented bits read zero
      case (ARADDR)
        opmode_pkg::MODE_CTRL_OFS: begin
          RDATA[7:0] <= {cfg.clk_div_select, 1'b0, low_osc_ready, high_osc_ready,
                         cfg.idle_enable, cfg.high_clk_select};
        end
        opmode_pkg::MODE_EXT_OFS: begin
          RDATA[7:0] <= {cfg.idle_clk_keep, 7'h00};
        end
        opmode_pkg::MODE_STAT_OFS: begin
          RDATA[7:0] <= {6'h00, watchdog_expiry_flag, power_down_flag};
        end
        default: begin
          RRESP <= opmode_pkg::AXI_SLVERR;
        end
      endcase
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end
endmodule // opmode_clock_ctrl

// ===== tb/opmode_asserts.sv
// checker: port-level assertions for the operating mode clock control block
`timescale 1ns/1ps
module opmode_asserts (
  input logic CLK,
  input logic RST_B,
  input logic HALT_EXEC,
  input logic WAKE_UP,
  input logic FAST_OSC_ENABLE,
  input logic [2:0] OP_MODE,
  input logic BVALID,
  input logic [1:0] BRESP,
  input logic RVALID,
  input logic [31:0] RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // ==========================================
  // mode entry and exit
  halt_entry_a: assert property (HALT_EXEC && OP_MODE <= 3'h1 |-> ##2 OP_MODE inside {[3'h2:3'h5]})
    else $error("halt did not reach a low-power mode");
  halt_exit_a: assert property (WAKE_UP && OP_MODE >= 3'h2 |-> ##[1:4] OP_MODE <= 3'h1)
    else $error("wake-up did not return to a running mode");
  mode_hold_a: assert property (OP_MODE >= 3'h2 && !WAKE_UP && !$past(WAKE_UP)
      && !$past(WAKE_UP, 2) |=> $stable(OP_MODE))
    else $error("low-power mode left without wake-up");

  // ==========================================
  // fast oscillator control
  slow_entry_a: assert property (OP_MODE == 3'h1 && $past(OP_MODE) == 3'h0 |-> !FAST_OSC_ENABLE)
    else $error("fast oscillator left on after move to sub clock");
  idle_off_a: assert property (OP_MODE == 3'h2 && !$past(WAKE_UP)
      && $past(OP_MODE) == 3'h2 |-> !FAST_OSC_ENABLE)
    else $error("fast oscillator running in idle with clock off");
  idle_keep_a: assert property (OP_MODE == 3'h3 && $past(OP_MODE) == 3'h0 |-> FAST_OSC_ENABLE)
    else $error("fast oscillator stopped in idle with clock kept");
  sleep_off_a: assert property ((OP_MODE inside {3'h4, 3'h5})[*2] ##0 !$past(WAKE_UP)
      |-> !FAST_OSC_ENABLE)
    else $error("fast oscillator running in sleep");

  // ==========================================
  // read data
  read_zero_a: assert property (RVALID |-> RDATA[31:8] == 24'h000000 && !RDATA[4])
    else $error("unimplemented bits read nonzero");

  cover property (OP_MODE == 3'h4);
  cover property (OP_MODE == 3'h1);
  cover property (BVALID && BRESP == opmode_pkg::AXI_SLVERR);
endmodule // opmode_asserts

bind opmode_clock_ctrl opmode_asserts opmode_asserts_inst (
  .CLK(CLK), .RST_B(RST_B), .HALT_EXEC(HALT_EXEC), .WAKE_UP(WAKE_UP),
  .FAST_OSC_ENABLE(FAST_OSC_ENABLE), .OP_MODE(OP_MODE), .BVALID(BVALID), .BRESP(BRESP),
  .RVALID(RVALID), .RDATA(RDATA)
);

// ===== tb/opmode_clock_control_tb.sv
// testbench: self-checking bench for the operating mode clock control block
`timescale 1ns/1ps
module opmode_clock_control_tb;
  localparam logic [3:0] CTRL = opmode_pkg::MODE_CTRL_OFS;
  localparam logic [3:0] EXT = opmode_pkg::MODE_EXT_OFS;
  localparam logic [3:0] STAT = opmode_pkg::MODE_STAT_OFS;
  logic CLK = 1'b0, RST_B = 1'b0, FAST_RC_OSC = 1'b0, SLOW_RC_OSC = 1'b0;
  logic HALT_EXEC = 1'b0, WAKE_UP = 1'b0, WDT_ENABLE = 1'b0, WDT_EXPIRY_SET = 1'b0;
  logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, FAST_OSC_ENABLE;
  logic CORE_CLOCK, CPU_CLOCK, SUB_CLOCK, TIMEBASE_CLOCK, CORE_TICK;
  logic [1:0] BRESP, RRESP, rsp;
  logic [31:0] RDATA, rd;
  logic [2:0] OP_MODE;
  logic [3:0] act;
  int n_fail = 0, checked = 0, cycles = 0, dcore = 0;
  int n_core = 0, n_cpu = 0, n_sub = 0, n_tb = 0;

  // ==========================================
  // clocks, edge counters, timeout
  always #5 CLK = ~CLK;
  always #62.5 FAST_RC_OSC = ~FAST_RC_OSC;
  // slow oscillator scaled to 2 MHz so the run stays short
  always #250 SLOW_RC_OSC = ~SLOW_RC_OSC;
  always @(posedge CORE_CLOCK) n_core++;
  always @(posedge CPU_CLOCK) n_cpu++;
  always @(posedge SUB_CLOCK) n_sub++;
  always @(posedge TIMEBASE_CLOCK) n_tb++;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      end_sim();
    end
  end

  opmode_clock_ctrl #(.STABLE_CYC(4)) opmode_clock_ctrl_inst (
    .CLK(CLK), .RST_B(RST_B), .FAST_RC_OSC(FAST_RC_OSC), .SLOW_RC_OSC(SLOW_RC_OSC),
    .HALT_EXEC(HALT_EXEC), .WAKE_UP(WAKE_UP), .WDT_ENABLE(WDT_ENABLE),
    .WDT_EXPIRY_SET(WDT_EXPIRY_SET), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .CORE_CLOCK(CORE_CLOCK),
    .CPU_CLOCK(CPU_CLOCK), .SUB_CLOCK(SUB_CLOCK), .TIMEBASE_CLOCK(TIMEBASE_CLOCK),
    .FAST_OSC_ENABLE(FAST_OSC_ENABLE), .CORE_TICK(CORE_TICK), .OP_MODE(OP_MODE)
  );

  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!b) begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      if (BVALID && BREADY) begin
        b = 1'b1;
        rsp = BRESP;
        BREADY <= 1'b0;
      end
    end
  endtask

  task automatic rd_reg(input logic [3:0] a);
    logic r;
    r = 1'b0;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!r) begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID && RREADY) begin
        r = 1'b1;
        rd = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
      end
    end
  endtask

  // activity of core, cpu, sub and timebase clocks over n cycles
  task automatic count_act(input int n);
    int c0, c1, c2, c3;
    c0 = n_core;
    c1 = n_cpu;
    c2 = n_sub;
    c3 = n_tb;
    repeat (n) @(posedge CLK);
    dcore = n_core - c0;
    act = {dcore > 1, n_cpu - c1 > 1, n_sub - c2 > 1, n_tb - c3 > 1};
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset;
    repeat (300) @(posedge CLK);
    chk("mode", OP_MODE, 32'h0);
    rd_reg(CTRL);
    chk("ctrl", rd, 32'h0000000F);
    wr(EXT, 32'h000000FF);
    rd_reg(EXT);
    chk("ext", rd, 32'h00000080);
    wr(4'hC, 32'h000000FF);
    chk("wr_resp", rsp, opmode_pkg::AXI_SLVERR);
    rd_reg(4'hC);
    chk("rd_resp", rsp, opmode_pkg::AXI_SLVERR);
    wr(EXT, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_div;
    int exp;
    for (int s = 0; s < 9; s++) begin
      wr(CTRL, (s == 8) ? 32'h00000001 : {24'h0, 3'(s), 5'h00});
      repeat (200) @(posedge CLK);
      count_act(1600);
      exp = (s == 8) ? 128 : (s < 2) ? 32 : (128 >> (8 - s));
      chk("core_edges", (dcore >= exp - 1 && dcore <= exp + 1), 32'h1);
      chk("mode", OP_MODE, (s < 2) ? 32'h1 : 32'h0);
      chk("fast_on", FAST_OSC_ENABLE, s >= 2);
      chk("run_clks", act[2:0], 32'h7);
      if (s < 2 || s == 8) chk("core_tick", CORE_TICK, s == 8);
      rd_reg(CTRL);
      chk("ctrl", rd, (s == 8) ? 32'h0D : {24'h0, 3'(s), 2'b01, 1'(s >= 2), 2'b00});
    end
    $display("test divide done");
  endtask

  task automatic t_halt;
    // idle enable, clock keep, watchdog, mode, activity of core cpu sub timebase
    logic [9:0] tbl [4] = '{10'b100_010_0011, 10'b110_011_1011, 10'b000_100_0000,
      10'b001_101_0010};
    for (int i = 0; i < 4; i++) begin
      wr(CTRL, {30'h0, tbl[i][9], 1'b1});
      wr(EXT, {24'h0, tbl[i][8], 7'h00});
      @(posedge CLK);
      WDT_ENABLE <= tbl[i][7];
      WDT_EXPIRY_SET <= 1'b1;
      @(posedge CLK);
      WDT_EXPIRY_SET <= 1'b0;
      HALT_EXEC <= 1'b1;
      @(posedge CLK);
      HALT_EXEC <= 1'b0;
      count_act(300);
      chk("mode", OP_MODE, tbl[i][6:4]);
      chk("clk_act", act, tbl[i][3:0]);
      rd_reg(STAT);
      chk("status", rd, 32'h1);
      rd_reg(CTRL);
      chk("low_rdy", rd[3], i != 2);
      @(posedge CLK);
      WAKE_UP <= 1'b1;
      @(posedge CLK);
      WAKE_UP <= 1'b0;
      repeat (130) @(posedge CLK);
      chk("woke", OP_MODE, 32'h0);
      rd_reg(CTRL);
      chk("low_rdy_wake", rd[3], 32'h1);
      wr(STAT, 32'h0);
    end
    $display("test halt done");
  endtask

  task automatic end_sim;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge CLK);
    RST_B <= 1'b1;
    t_reset();
    t_div();
    t_halt();
    end_sim();
  end
endmodule // opmode_clock_control_tb
